// ### testbench/test_mgmt_unit_image_locator.sv
// Self-checking bench for the management unit image locator
`timescale 1ns/1ps
`default_nettype none

module test_mgmt_unit_image_locator;
    // Stimulus and observed signals
    logic                      core_clk;
    logic                      rst_n;
    logic                      warm_rst;
    logic                      secure_variant;
    logic                      boot_strap;
    logic                      msg_valid;
    mgiloc_pkg::mgiloc_msg_t   msg_req;
    logic                      msg_ack;
    logic [31:0]               msg_rdata;
    logic                      fetch_req;
    mgiloc_pkg::mgiloc_fetch_t fetch_cmd;
    logic                      fetch_done;
    logic                      code_from_dram;
    logic [15:0]               code_base;
    logic                      recovery_boot;
    logic [4:0]                evt;
    logic [31:0]               rd_word;
    logic [31:0]               exp_st;
    int                        error_cnt;
    int                        compares;

    mgiloc_top dut_u (
        .core_clk             (core_clk),
        .rst_n                (rst_n),
        .warm_rst             (warm_rst),
        .secure_variant       (secure_variant),
        .boot_strap           (boot_strap),
        .msg_valid            (msg_valid),
        .msg_req              (msg_req),
        .msg_ack              (msg_ack),
        .msg_rdata            (msg_rdata),
        .fetch_req            (fetch_req),
        .fetch_cmd            (fetch_cmd),
        .fetch_done           (fetch_done),
        .code_from_dram       (code_from_dram),
        .code_base            (code_base),
        .recovery_boot        (recovery_boot),
        .unit_warm_reset_init (evt[4]),
        .double_ecc_err       (evt[3]),
        .isolated_region_viol (evt[2]),
        .host_boundary_viol   (evt[1]),
        .sysmgmt_memory_viol  (evt[0])
    );

    // 125 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Four-state compare so an unknown never passes
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // One request; ack and read data stand only in the cycle after it is taken
    task automatic msg(input logic [7:0] op, input logic [7:0] pt, input logic [15:0] off,
                       input logic [31:0] wd);
        @(posedge core_clk);
        msg_valid <= 1'b1;
        msg_req   <= {op, pt, off, wd};
        @(posedge core_clk);
        msg_valid <= 1'b0;
        #1;
        check({63'h0, msg_ack}, 64'h1, "message ack");
        rd_word = msg_rdata;
    endtask

    task automatic read_status(input logic [31:0] exp, input string what);
        msg(mgiloc_pkg::OP_CFG_RD, mgiloc_pkg::PORT_CFG, mgiloc_pkg::REG_STICKY, 32'h0);
        check({32'h0, rd_word}, {32'h0, exp}, what);
    endtask

    // Waits a bounded time for the boot fetch, then completes it
    task automatic run_fetch(input logic [31:0] addr);
        int n;
        n = 0;
        while (fetch_req !== 1'b1 && n < 20) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check({15'h0, fetch_req, fetch_cmd}, {15'h0, 1'b1, addr, mgiloc_pkg::FIRST_LEN},
              "boot fetch");
        @(posedge core_clk);
        fetch_done <= 1'b1;
        @(posedge core_clk);
        fetch_done <= 1'b0;
        #1;
        check({63'h0, fetch_req}, 64'h0, "fetch end");
    endtask

    task automatic cold_reset();
        rst_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
    endtask

    task automatic warm_reset();
        @(posedge core_clk);
        warm_rst <= 1'b1;
        @(posedge core_clk);
        warm_rst <= 1'b0;
    endtask

    // Secure boot from the fixed ROM address, status clear after cold reset
    task automatic t_secure_boot();
        secure_variant <= 1'b1;
        cold_reset();
        read_status(32'h0, "status after cold reset");
        run_fetch(mgiloc_pkg::ROM_TRUST_ADDR);
    endtask

    // Misaddressed base write must not relocate; the proper one must
    task automatic t_relocate();
        msg(mgiloc_pkg::OP_BASE_READY, mgiloc_pkg::PORT_CFG, mgiloc_pkg::REG_BASE, 32'h5555_0000);
        @(posedge core_clk);
        #1;
        check({63'h0, code_from_dram}, 64'h0, "wrong port base");
        msg(mgiloc_pkg::OP_CFG_RD, mgiloc_pkg::PORT_HOST, mgiloc_pkg::REG_STICKY, 32'h0);
        check({32'h0, rd_word}, 64'h0, "unmapped read");
        // after memory init: relocation only once the boot fetch is over
        // aligned base: low half of the address is zero
        // reserved region: base follows any later base-ready write until the next reset
        msg(mgiloc_pkg::OP_BASE_READY, mgiloc_pkg::PORT_HOST, mgiloc_pkg::REG_BASE, 32'h1234_0000);
        @(posedge core_clk);
        #1;
        check({47'h0, code_from_dram, code_base}, {47'h0, 1'b1, 16'h1234}, "dram");
    endtask

    // Each event sets its own flag; flags accumulate
    task automatic t_events();
        exp_st = 32'h0;
        for (int i = 0; i < 5; i++) begin
            @(posedge core_clk);
            evt <= 5'h01 << i;
            @(posedge core_clk);
            evt <= 5'h00;
            exp_st[i] = 1'b1;
            read_status(exp_st, "event flag");
        end
        exp_st[mgiloc_pkg::BIT_RECOVERY] = 1'b1;
        msg(mgiloc_pkg::OP_CFG_WR, mgiloc_pkg::PORT_CFG, mgiloc_pkg::REG_STICKY, exp_st);
        read_status(exp_st, "recovery request write");
        // event wins: a write clearing the flags meets an ECC event in one cycle
        @(posedge core_clk);
        msg_valid <= 1'b1;
        msg_req   <= {mgiloc_pkg::OP_CFG_WR, mgiloc_pkg::PORT_CFG, mgiloc_pkg::REG_STICKY,
                      32'h0000_0200};
        evt       <= 5'h08;
        @(posedge core_clk);
        msg_valid <= 1'b0;
        evt       <= 5'h00;
        exp_st = 32'h0000_0208;
        read_status(exp_st, "event set wins over write");
    endtask

    // Warm reset keeps status and restarts a strap-selected boot from flash
    task automatic t_warm();
        for (int s = 0; s < 2; s++) begin
            @(posedge core_clk);
            secure_variant <= 1'b0;
            boot_strap     <= s[0];
            warm_reset();
            run_fetch(s == 0 ? mgiloc_pkg::STRAP0_ADDR : mgiloc_pkg::STRAP1_ADDR);
            read_status(exp_st, "status after warm reset");
            check({62'h0, recovery_boot, code_from_dram}, {62'h0, 2'b10}, "warm boot");
        end
    endtask

    // A second cold reset clears every sticky bit
    task automatic t_cold_clear();
        cold_reset();
        read_status(32'h0, "status after second cold reset");
        run_fetch(mgiloc_pkg::STRAP1_ADDR);
        check({63'h0, recovery_boot}, 64'h0, "recovery after cold");
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence; all inputs defined at time zero
    initial begin
        rst_n          = 1'b0;
        warm_rst       = 1'b0;
        secure_variant = 1'b0;
        boot_strap     = 1'b0;
        msg_valid      = 1'b0;
        msg_req        = '0;
        fetch_done     = 1'b0;
        evt            = 5'h00;
        error_cnt      = 0;
        compares       = 0;
        t_secure_boot();
        t_relocate();
        t_events();
        t_warm();
        t_cold_clear();
        complete_run();
    end

    // Watchdog: the sequence needs a few hundred cycles at most
    initial begin
        repeat (4000) @(posedge core_clk);
        error_cnt++;
        complete_run();
    end
endmodule

`default_nettype wire

// ### verilog/mgiloc_pkg.sv
// Constants and types for the management unit image locator
package mgiloc_pkg;

    // Message opcodes
    localparam logic [7:0]  OP_CFG_RD     = 8'h06;
    localparam logic [7:0]  OP_CFG_WR     = 8'h07;
    localparam logic [7:0]  OP_BASE_READY = 8'h78;

    // Message ports and register offsets
    localparam logic [7:0]  PORT_CFG      = 8'h31;
    localparam logic [7:0]  PORT_HOST     = 8'h04;
    localparam logic [15:0] REG_STICKY    = 16'h0051;
    localparam logic [15:0] REG_BASE      = 16'h0000;

    // First-stage image locations and size
    localparam logic [31:0] ROM_TRUST_ADDR = 32'hfffe0000;
    localparam logic [31:0] STRAP0_ADDR    = 32'hfff00000;
    localparam logic [31:0] STRAP1_ADDR    = 32'hffd00000;
    localparam logic [15:0] FIRST_LEN      = 16'h0800;

    // Base-ready payload layout
    localparam int          BASE_LSB      = 16;
    localparam int          BASE_MSB      = 31;
    localparam logic [15:0] BASE_LOW_ZERO = 16'h0000;

    // Persistent status register layout
    localparam logic [31:0] STICKY_RST    = 32'h00000000;
    localparam int          BIT_RECOVERY  = 9;
    localparam int          BIT_UNIT_WARM = 4;
    localparam int          BIT_ECC       = 3;
    localparam int          BIT_ISO       = 2;
    localparam int          BIT_HOSTB     = 1;
    localparam int          BIT_SMM       = 0;
    localparam int          EVT_W         = 5;

    // Message request carried as one word
    typedef struct packed {
        logic [7:0]  opcode;
        logic [7:0]  port;
        logic [15:0] offset;
        logic [31:0] wdata;
    } mgiloc_msg_t;

    // Image fetch command
    typedef struct packed {
        logic [31:0] addr;
        logic [15:0] len;
    } mgiloc_fetch_t;

    // Boot states
    typedef enum logic [1:0] {
        ST_SAMPLE,
        ST_FETCH,
        ST_FLASH,
        ST_DRAM
    } mgiloc_state_t;

endpackage

// ### verilog/mgiloc_top.sv
// Management unit image locator: boot fetch, DRAM relocation, persistent status
`timescale 1ns/1ps
`default_nettype none

module mgiloc_top (
    // Clock and resets
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    input  wire logic                     warm_rst,
    // Straps
    input  wire logic                     secure_variant,
    input  wire logic                     boot_strap,
    // Message port
    input  wire logic                     msg_valid,
    input  wire mgiloc_pkg::mgiloc_msg_t  msg_req,
    output logic                          msg_ack,
    output logic [31:0]                   msg_rdata,
    // Image fetch
    output logic                          fetch_req,
    output mgiloc_pkg::mgiloc_fetch_t     fetch_cmd,
    input  wire logic                     fetch_done,
    // Code source
    output logic                          code_from_dram,
    output logic [15:0]                   code_base,
    output logic                          recovery_boot,
    // Unit events
    input  wire logic                     unit_warm_reset_init,
    input  wire logic                     double_ecc_err,
    input  wire logic                     isolated_region_viol,
    input  wire logic                     host_boundary_viol,
    input  wire logic                     sysmgmt_memory_viol
);

    // Decode a message against one register
    function automatic logic msg_hit(input mgiloc_pkg::mgiloc_msg_t m,
                                     input logic [7:0] op,
                                     input logic [7:0] port,
                                     input logic [15:0] off);
        msg_hit = (m.opcode == op) && (m.port == port) && (m.offset == off);
    endfunction

    mgiloc_pkg::mgiloc_state_t state_q;
    logic [31:0]               sticky_q;
    logic [31:0]               sticky_d;
    logic                      base_seen_q;
    logic [15:0]               base_q;
    logic                      wr_sticky;
    logic                      rd_sticky;
    logic                      wr_base;
    logic [4:0]                evt;

    assign wr_sticky = msg_valid && msg_hit(msg_req, mgiloc_pkg::OP_CFG_WR,
                                            mgiloc_pkg::PORT_CFG, mgiloc_pkg::REG_STICKY);
    assign rd_sticky = msg_valid && msg_hit(msg_req, mgiloc_pkg::OP_CFG_RD,
                                            mgiloc_pkg::PORT_CFG, mgiloc_pkg::REG_STICKY);
    assign wr_base   = msg_valid && msg_hit(msg_req, mgiloc_pkg::OP_BASE_READY,
                                            mgiloc_pkg::PORT_HOST, mgiloc_pkg::REG_BASE);
    assign evt = {unit_warm_reset_init, double_ecc_err, isolated_region_viol,
                  host_boundary_viol, sysmgmt_memory_viol};

    // Next status value: software write first, then hardware sets on top
    always_comb begin
        sticky_d = sticky_q;
        if (wr_sticky) begin
            sticky_d = msg_req.wdata;
        end
        if (evt[4]) begin
            sticky_d[mgiloc_pkg::BIT_UNIT_WARM] = 1'b1;
        end
        if (evt[3]) begin
            sticky_d[mgiloc_pkg::BIT_ECC] = 1'b1;
        end
        if (evt[2]) begin
            sticky_d[mgiloc_pkg::BIT_ISO] = 1'b1;
        end
        if (evt[1]) begin
            sticky_d[mgiloc_pkg::BIT_HOSTB] = 1'b1;
        end
        if (evt[0]) begin
            sticky_d[mgiloc_pkg::BIT_SMM] = 1'b1;
        end
    end

    // Persistent status: warm reset is not looked at here on purpose
    // survives warm reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sticky_q <= mgiloc_pkg::STICKY_RST;
        end else begin
            sticky_q <= sticky_d;
        end
    end

    // Message answers: every request is acked one cycle later
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            msg_ack   <= 1'b0;
            msg_rdata <= 32'h00000000;
        end else begin
            msg_ack   <= msg_valid;
            msg_rdata <= rd_sticky ? sticky_q : 32'h00000000; // Unmapped reads zero
        end
    end

    // Base-ready capture; low half is ignored, the host must send zeros
    // upper half taken
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            base_seen_q <= 1'b0;
            base_q      <= 16'h0000;
        end else if (warm_rst) begin
            base_seen_q <= 1'b0;
            base_q      <= 16'h0000;
        end else if (wr_base) begin
            base_seen_q <= 1'b1;
            base_q      <= msg_req.wdata[mgiloc_pkg::BASE_MSB:mgiloc_pkg::BASE_LSB];
        end
    end

    // Boot sequence; straps caught one edge after reset release, not under reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q        <= mgiloc_pkg::ST_SAMPLE;
            fetch_req      <= 1'b0;
            fetch_cmd      <= '0;
            code_from_dram <= 1'b0;
            code_base      <= 16'h0000;
            recovery_boot  <= 1'b0;
        end else if (warm_rst) begin
            state_q        <= mgiloc_pkg::ST_SAMPLE;
            fetch_req      <= 1'b0;
            code_from_dram <= 1'b0;
        end else begin
            case (state_q)
                mgiloc_pkg::ST_SAMPLE: begin
                    fetch_req     <= 1'b1;
                    fetch_cmd.len <= mgiloc_pkg::FIRST_LEN;
                    recovery_boot <= sticky_q[mgiloc_pkg::BIT_RECOVERY];
                    if (secure_variant) begin
                        fetch_cmd.addr <= mgiloc_pkg::ROM_TRUST_ADDR;
                    end else begin
                        fetch_cmd.addr <= boot_strap ? mgiloc_pkg::STRAP1_ADDR
                                                     : mgiloc_pkg::STRAP0_ADDR;
                    end
                    state_q <= mgiloc_pkg::ST_FETCH;
                end
                mgiloc_pkg::ST_FETCH: begin
                    if (fetch_done) begin
                        fetch_req <= 1'b0;
                        state_q   <= mgiloc_pkg::ST_FLASH;
                    end
                end
                mgiloc_pkg::ST_FLASH: begin
                    if (base_seen_q) begin
                        code_from_dram <= 1'b1;
                        code_base      <= base_q;
                        state_q        <= mgiloc_pkg::ST_DRAM;
                    end
                end
                mgiloc_pkg::ST_DRAM: begin
                    // A later base-ready write moves the image again
                    code_base <= base_q;
                end
                default: begin
                    state_q <= mgiloc_pkg::ST_SAMPLE;
                end
            endcase
        end
    end

    // Checks

    chk_secure_fetch_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_q == mgiloc_pkg::ST_SAMPLE && !warm_rst && secure_variant)
        |=> (fetch_req && fetch_cmd.addr == mgiloc_pkg::ROM_TRUST_ADDR
             && fetch_cmd.len == mgiloc_pkg::FIRST_LEN))
        else $error("secure fetch address wrong");

    chk_strap_fetch_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_q == mgiloc_pkg::ST_SAMPLE && !warm_rst && !secure_variant)
        |=> (fetch_cmd.addr == ($past(boot_strap) ? mgiloc_pkg::STRAP1_ADDR
                                                  : mgiloc_pkg::STRAP0_ADDR)))
        else $error("strap fetch address wrong");

    chk_fetch_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_q == mgiloc_pkg::ST_FETCH && !fetch_done && !warm_rst) |=> fetch_req)
        else $error("fetch request dropped early");

    chk_dram_switch: assert property (@(posedge core_clk) disable iff (!rst_n || warm_rst)
        (wr_base && state_q == mgiloc_pkg::ST_FLASH)
        ##2 (state_q == mgiloc_pkg::ST_DRAM)
        |-> (code_from_dram && code_base == $past(msg_req.wdata[31:16], 2)))
        else $error("code base not taken from base-ready write");

    chk_warm_keeps: assert property (@(posedge core_clk) disable iff (!rst_n)
        (warm_rst && !msg_valid && evt == 5'h00) |=> $stable(sticky_q))
        else $error("status changed across warm reset");

    chk_recovery_rw: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_sticky |=> (sticky_q[mgiloc_pkg::BIT_RECOVERY]
                       == $past(msg_req.wdata[mgiloc_pkg::BIT_RECOVERY])))
        else $error("recovery bit write not stored");

    // unit warm reset flag set wins
    chk_unit_warm_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        unit_warm_reset_init |=> sticky_q[mgiloc_pkg::BIT_UNIT_WARM])
        else $error("unit warm reset flag not set");

    chk_ecc_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        double_ecc_err |=> sticky_q[mgiloc_pkg::BIT_ECC])
        else $error("ECC flag not set");

    chk_iso_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        isolated_region_viol |=> sticky_q[mgiloc_pkg::BIT_ISO])
        else $error("isolated region flag not set");

    chk_hostb_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        host_boundary_viol |=> sticky_q[mgiloc_pkg::BIT_HOSTB])
        else $error("host boundary flag not set");

    chk_smm_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        sysmgmt_memory_viol |=> sticky_q[mgiloc_pkg::BIT_SMM])
        else $error("system management flag not set");

    chk_flag_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
        ($rose(sticky_q[mgiloc_pkg::BIT_ECC]) |-> $past(double_ecc_err || wr_sticky)))
        else $error("ECC flag rose without cause");

    // Main scenarios
    cov_boot_to_dram: cover property (@(posedge core_clk) disable iff (!rst_n)
        $rose(code_from_dram));
    cov_warm_recovery: cover property (@(posedge core_clk) disable iff (!rst_n)
        warm_rst ##2 recovery_boot);
    cov_event_set: cover property (@(posedge core_clk) disable iff (!rst_n)
        wr_sticky && double_ecc_err);

endmodule

`default_nettype wire
